// ### rtl/sdl_device.sv
/*
  Converter end: samples the three link pins, shifts frames, loads the latch.
  Assumes link pins are asynchronous to clk_in; rst_n_in is the power-on reset.
*/
`timescale 1ns/1ps
module sdl_device
  import sdl_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  sdl_link_if.device                 link,
  output logic [CODE_BITS-1:0]       dac_code_out,
  output logic [1:0]                 power_down_select_out,
  output logic                       shutdown_out,
  output logic                       load_pulse_out,
  output logic                       frame_error_out
);
  // Packed state: synchroniser, shift path and converter latch
  typedef struct packed {
    logic [PIN_COUNT-1:0]   s1;     // First stage, read by s2 only
    logic [PIN_COUNT-1:0]   s2;     // Second stage, safe to decode
    logic                   clk_d;  // Synchronised clock one cycle ago
    logic                   sel_d;  // Synchronised select one cycle ago
    logic [FRAME_BITS-1:0]  sh;     // Input shift register
    logic [CNT_BITS-1:0]    cnt;    // Rises seen in this frame, saturating
    logic [CODE_BITS-1:0]   code;   // Converter latch, code part
    logic [MODE_BITS-1:0]   mode;   // Converter latch, mode part
    logic                   load;   // Latch transfer strobe
    logic                   err;    // Last frame cut short
  } sdl_dev_type;

  sdl_dev_type                 s_reg;
  sdl_dev_type                 s_next;
  logic                        sel_sync;
  logic                        data_sync;
  logic                        clk_sync;
  logic                        sel_low;
  logic                        clk_rise;
  logic                        sel_rise;
  logic                        shift_en;
  logic                        cnt_full;
  logic [CNT_BITS-1:0]         cnt_inc;
  logic [FRAME_BITS-1:0]       sh_shifted;
  logic                        good_load;
  logic                        bad_load;
  logic [MODE_BITS-1:0]        word_mode;
  logic [CODE_BITS-1:0]        word_code;
  logic                        shutdown;

  // Synchronised pin levels, named by function
  assign sel_sync  = s_reg.s2[PIN_SEL];
  assign data_sync = s_reg.s2[PIN_DAT];
  assign clk_sync  = s_reg.s2[PIN_CLK];

  // Edge finding; reset values match idle pins so no false rise follows
  assign sel_low  = ~sel_sync;
  assign clk_rise = clk_sync & ~s_reg.clk_d;                          // see RULE5
  assign sel_rise = sel_sync & ~s_reg.sel_d;

  // Shift path: one bit per clock rise while selected, first bit ends on top
  assign shift_en   = sel_low & clk_rise;                             // see RULE1
  assign sh_shifted = {s_reg.sh[FRAME_BITS-2:0], data_sync};          // see RULE13
  assign cnt_full   = (s_reg.cnt == CNT_FULL);
  assign cnt_inc    = cnt_full ? s_reg.cnt : s_reg.cnt + 5'h1;

  // Frame end: a full frame loads, anything shorter is corrupt
  assign good_load = sel_rise & cnt_full;                             // see RULE2
  assign bad_load  = sel_rise & ~cnt_full;                            // see RULE3

  // Fields of the finished word
  assign word_mode = s_reg.sh[MODE_LSB+MODE_BITS-1:MODE_LSB];         // see RULE9
  assign word_code = s_reg.sh[CODE_LSB+CODE_BITS-1:CODE_LSB];         // see RULE7

  // Next state: sample pins, shift, count and transfer to the latch
  always_comb
  begin
    s_next              = s_reg;
    s_next.s1[PIN_SEL]  = link.sel_n;
    s_next.s1[PIN_DAT]  = link.sdata;
    s_next.s1[PIN_CLK]  = link.sclk;
    s_next.s2           = s_reg.s1;
    s_next.clk_d        = clk_sync;
    s_next.sel_d        = sel_sync;
    s_next.load         = 1'b0;
    if (shift_en)
    begin
      s_next.sh  = sh_shifted;
      s_next.cnt = cnt_inc;
    end
    if (sel_rise)
    begin
      s_next.cnt = '0;
    end
    if (good_load)
    begin
      s_next.mode = word_mode;
      s_next.code = word_code;
      s_next.load = 1'b1;
      s_next.err  = 1'b0;                                             // see RULE4
    end
    if (bad_load)
    begin
      s_next.err = 1'b1;                                              // see RULE3
    end
  end

  // State register; reset clears latch to zero code, normal mode
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_reg       <= '0;                                              // see RULE11
      s_reg.s1    <= PINS_IDLE;
      s_reg.s2    <= PINS_IDLE;
      s_reg.clk_d <= PINS_IDLE[PIN_CLK];
      s_reg.sel_d <= PINS_IDLE[PIN_SEL];
    end
    else if (ce_in)
    begin
      s_reg <= s_next;
    end
  end

  // Any shutdown mode parks the converter at zero
  assign shutdown = (s_reg.mode != MODE_NORMAL);                      // see RULE10

  // Per-bit code gating; output is code times reference over 64
  for (genvar b = 0; b < CODE_BITS; b++)
  begin : g_code
    assign dac_code_out[b] = shutdown ? CODE_RESET[b] : s_reg.code[b]; // see RULE8
  end

  // Latch and status outputs, all from registers
  assign shutdown_out          = shutdown;
  assign power_down_select_out = s_reg.mode;
  assign load_pulse_out        = s_reg.load;
  assign frame_error_out       = s_reg.err;
endmodule : sdl_device

// ### rtl/sdl_link_if.sv
/*
  Three-wire link between serial master and converter loader.
  Assumes both ends are instantiated by a surrounding bench.
*/
`timescale 1ns/1ps
interface sdl_link_if;
  logic sel_n;
  logic sdata;
  logic sclk;

  modport master (output sel_n, output sdata, output sclk);
  modport device (input sel_n, input sdata, input sclk);
endinterface : sdl_link_if

// ### rtl/sdl_master.sv
/*
  Serial master end: sends one 16-bit word per accepted request, MSB first.
  Assumes requests come from logic on clk_in; serial clock is made by division.
*/
`timescale 1ns/1ps
module sdl_master
  import sdl_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   ce_in,
  input  wire logic                   req_valid_in,
  input  wire logic [FRAME_BITS-1:0]  req_word_in,
  input  wire logic                   sclk_idle_in,
  output logic                        req_ready_out,
  sdl_link_if.master                  link
);
  typedef struct packed {
    sdl_mst_state_type      st;
    logic [FRAME_BITS-1:0]  sh;
    logic [CNT_BITS-1:0]    cnt;
    logic [HALF_BITS-1:0]   half;
    logic                   idle_lvl;
    logic                   sclk;
    logic                   sel_n;
    logic                   sdata;
  } sdl_mst_type;

  sdl_mst_type s_reg, s_next;

  // Sequencer: select low, data on falling half, rise samples, select high
  always_comb
  begin
    s_next = s_reg;
    if (s_reg.half != '0)
      s_next.half = s_reg.half - 4'h1;
    unique case (s_reg.st)
      M_IDLE:
      begin
        s_next.sclk = sclk_idle_in;                  // see RULE5
        if (req_valid_in && s_reg.half == '0)
        begin
          s_next.sh       = req_word_in;
          s_next.idle_lvl = sclk_idle_in;
          s_next.sel_n    = 1'b0;
          s_next.sclk     = 1'b0;
          s_next.sdata    = req_word_in[FRAME_BITS-1]; // see RULE13
          s_next.cnt      = '0;
          s_next.half     = HALF_LAST;
          s_next.st       = M_SETUP;
        end
      end
      M_SETUP:
        if (s_reg.half == '0)
        begin
          s_next.sclk = 1'b1;                        // see RULE6
          s_next.half = HALF_LAST;
          s_next.cnt  = s_reg.cnt + 5'h1;
          s_next.st   = M_SHIFT;
        end
      M_SHIFT:
        if (s_reg.half == '0)
        begin
          s_next.half = HALF_LAST;
          if (s_reg.cnt == CNT_FULL)                 // see RULE3
          begin
            s_next.sclk = 1'b1;
            s_next.st   = M_END;
          end
          else
          begin
            s_next.sclk  = 1'b0;
            s_next.sh    = {s_reg.sh[FRAME_BITS-2:0], 1'b0};
            s_next.sdata = s_reg.sh[FRAME_BITS-2];   // see RULE13
            s_next.st    = M_SETUP;
          end
        end
      M_END:
        if (s_reg.half == '0)
        begin
          s_next.sel_n = 1'b1;                       // see RULE12
          s_next.sclk  = s_reg.idle_lvl;
          s_next.half  = HALF_LAST;                  // Select stays high a half period
          s_next.st    = M_IDLE;
        end
      default:
        s_next = s_reg;
    endcase
  end

  // State register with clock enable
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_reg       <= '0;
      s_reg.st    <= M_IDLE;
      s_reg.sel_n <= 1'b1;
    end
    else if (ce_in)
      s_reg <= s_next;
  end

  assign req_ready_out = (s_reg.st == M_IDLE) && (s_reg.half == '0);
  assign link.sel_n    = s_reg.sel_n;
  assign link.sdata    = s_reg.sdata;
  assign link.sclk     = s_reg.sclk;
endmodule : sdl_master

// ### rtl/sdl_pkg.sv
/*
  Constants and types shared by both ends of the six-bit converter serial loader.
  Assumes a single 100 MHz system clock at each end and a 3-wire write-only link.
*/
// Function
// RULE1: select low, shift bit each clock rise
// RULE2: full frame copied to latch on select rise
// RULE3: master holds select low all 16 clocks
// RULE4: after corrupt frame, master resends full word; sdl_master has no resend, device clears err on next full frame
// RULE5: clock may idle high or low
// RULE6: master serial clock at most 10 MHz
// RULE7: bits 11..6 form six-bit unipolar code
// RULE8: output equals code times reference over 64
// RULE9: bits 13..12 select normal or shutdown resistance
// RULE10: shutdown forces output to zero volts
// RULE11: power-on reset clears latch to zero
// RULE12: only select, data, clock; no readback
// RULE13: frames sent most significant bit first
package sdl_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam int          CODE_BITS      = 6;
  localparam int          CODE_LSB       = 6;
  localparam int          MODE_LSB       = 12;
  localparam int          MODE_BITS      = 2;
  // Pin positions inside the device's synchroniser vectors
  localparam int          PIN_COUNT      = 3;
  localparam int          PIN_SEL        = 2;
  localparam int          PIN_DAT        = 1;
  localparam int          PIN_CLK        = 0;
  // Pins as assumed at reset; all high so no false clock rise follows
  localparam logic [2:0]  PINS_IDLE      = 3'h7;
  localparam int          CNT_BITS       = 5;
  localparam logic [4:0]  CNT_FULL       = 5'h10;
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  MODE_SD_1K     = 2'h1;
  localparam logic [1:0]  MODE_SD_100K   = 2'h2;
  localparam logic [1:0]  MODE_SD_1M     = 2'h3;
  localparam logic [5:0]  CODE_RESET     = 6'h00;
  localparam int          CLK_MHZ        = 100;
  localparam int          SCLK_MAX_MHZ   = 10;
  // Half period of generated serial clock, rounded up so the rate stays at or below max
  localparam int          SCLK_HALF_CYC  = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int          HALF_BITS      = 4;
  localparam logic [3:0]  HALF_LAST      = 4'(SCLK_HALF_CYC - 1);

  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_SETUP = 4'h2,
    M_SHIFT = 4'h4,
    M_END   = 4'h8
  } sdl_mst_state_type;
endpackage : sdl_pkg

// ### tb/sdl_link_asserts.sv
/*
  Link checker: watches the three wires between master and device.
  Assumes the wires are sampled on clk_in of the master.
*/
`timescale 1ns/1ps
module sdl_link_asserts
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic sel_n_in,
  input  wire logic sdata_in,
  input  wire logic sclk_in
);
  logic [4:0] rise_cnt_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Counts clock rises inside one frame
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      rise_cnt_reg <= 5'h00;
    else if (sel_n_in)
      rise_cnt_reg <= 5'h00;
    else if ($rose(sclk_in))
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
  a_first_rise: assert property ($fell(sel_n_in) |-> (!sclk_in)[*5] ##1 sclk_in)
    else $error("first rise misplaced");
  a_high_half: assert property ($rose(sclk_in) && !sel_n_in |-> sclk_in[*5])
    else $error("clock high too short");
  a_rise_space: assert property ($rose(sclk_in) |=> (!$rose(sclk_in))[*8])
    else $error("clock faster than limit");
  a_data_hold: assert property (!sel_n_in && sclk_in && $past(sclk_in) |-> $stable(sdata_in))
    else $error("data moved while clock high");
  a_frame_len: assert property ($fell(sel_n_in) |-> ##[155:170] $rose(sel_n_in))
    else $error("frame length wrong");
  a_full_count: assert property ($rose(sel_n_in) |-> rise_cnt_reg == 5'h10)
    else $error("frame not sixteen bits");
  a_gap_cycle: assert property ($rose(sel_n_in) |-> sel_n_in[*5])
    else $error("no gap between frames");
  a_end_hold: assert property ($rose(sel_n_in) |-> $past(sclk_in))
    else $error("select rose before last rise");
endmodule : sdl_link_asserts

// ### tb/six_bit_dac_serial_loader_tb.sv
/*
  Bench: master drives device; a second device gets bench-made frames.
  Assumes 100 MHz clock and async active-low reset.
*/
`timescale 1ns/1ps
module six_bit_dac_serial_loader_tb;
  import sdl_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        req_valid = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic        idle = 1'b0;
  logic        ce_b = 1'b1;
  logic        ready, shut, shut_b, pulse, err, err_b;
  logic [5:0]  code, code_b;
  logic [1:0]  mode, mode_b;
  logic [31:0] rng = 32'h000036B3;
  logic [15:0] corner [4] = '{16'hCFFF, 16'h1FC0, 16'h2FFF, 16'hF03F};
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  sdl_link_if link ();
  sdl_link_if link_b ();
  // Free-running system clock
  always #5 clk_in = ~clk_in;
  sdl_master u_sdl_master (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .req_valid_in(req_valid), .req_word_in(req_word), .sclk_idle_in(idle),
    .req_ready_out(ready), .link(link));
  sdl_device u_sdl_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .link(link), .dac_code_out(code), .power_down_select_out(mode),
    .shutdown_out(shut), .load_pulse_out(pulse), .frame_error_out(err));
  sdl_device u_sdl_device_b (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_b),
    .link(link_b), .dac_code_out(code_b), .power_down_select_out(mode_b),
    .shutdown_out(shut_b), .load_pulse_out(), .frame_error_out(err_b));
  sdl_link_asserts u_sdl_link_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sel_n_in(link.sel_n), .sdata_in(link.sdata), .sclk_in(link.sclk));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Expected error, shutdown, mode and code after a good load
  function automatic logic [9:0] expect_of(input logic [15:0] w);
    return {1'b0, w[13:12] != MODE_NORMAL, w[13:12],
      (w[13:12] == MODE_NORMAL) ? w[11:6] : CODE_RESET};
  endfunction : expect_of
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    n_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // One word through the master, then the device outputs are compared
  task automatic send(input logic [15:0] w, input logic idl);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      k++;
    end while (ready !== 1'b1 && k < 400);
    req_word = w;
    idle = idl;
    req_valid = 1'b1;
    @(posedge clk_in);
    #1;
    req_valid = 1'b0;
    k = 0;
    while (pulse !== 1'b1 && k < 400)
    begin
      @(negedge clk_in);
      k++;
    end
    check({9'h000, pulse}, 10'h001);
    check({err, shut, mode, code}, expect_of(w));
  endtask : send
  // Bench-made frame of n bits on the second link, 125 ns clock
  task automatic bang(input logic [15:0] w, input int n, input logic idl);
    link_b.sclk = idl;
    #62.5;
    link_b.sel_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++)
    begin
      link_b.sclk = 1'b0;
      link_b.sdata = w[15-i];
      #62.5;
      link_b.sclk = 1'b1;
      #62.5;
    end
    link_b.sel_n = 1'b1;
    link_b.sdata = ~link_b.sdata;
    link_b.sclk = idl;
    #500;
  endtask : bang
  // Hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      error_cnt++;
      final_report();
    end
  end
  // Main sequence
  initial
  begin
    link_b.sel_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    check({err, shut, mode, code}, 10'h000);
    foreach (corner[i]) send(corner[i], i[0]);
    repeat (20)
    begin
      rng = xs(rng);
      send(rng[15:0], rng[16]);
    end
    $display("master path test done");
    bang(16'h0840, 16, 1'b1);
    check({err_b, shut_b, mode_b, code_b}, 10'h021);
    bang(16'h0FC0, 10, 1'b0);
    check({err_b, shut_b, mode_b, code_b}, 10'h221);
    bang(16'h0FC0, 16, 1'b0);
    check({err_b, shut_b, mode_b, code_b}, 10'h03F);
    @(posedge clk_in);
    #1;
    ce_b = 1'b0;
    bang(16'h1FC0, 16, 1'b1);
    @(posedge clk_in);
    #1;
    ce_b = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    check({err_b, shut_b, mode_b, code_b}, 10'h03F);
    $display("fault link test done");
    final_report();
  end
endmodule : six_bit_dac_serial_loader_tb
